/* plm_pkg.sv */
package plm_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] PLM_CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] PLM_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] PLM_KEY_OFFSET    = 8'h08;

  // Control register fields.
  localparam int PLM_CTRL_LOCK_LSB = 0;
  localparam int PLM_CTRL_ERASE    = 8;

  // Key register fields: byte data and key index.
  localparam int PLM_KEY_DATA_LSB  = 0;
  localparam int PLM_KEY_INDEX_LSB = 8;

  // Status register fields.
  localparam int PLM_STAT_LOCK_LSB  = 0;
  localparam int PLM_STAT_LEVEL_LSB = 4;
  localparam int PLM_STAT_ACCESS    = 8;

  // Encryption array geometry, erased values and the verify deny byte.
  localparam int          PLM_KEY_DEPTH   = 64;
  localparam int          PLM_KEY_IDX_W   = 6;
  localparam logic [7:0]  PLM_KEY_ERASED  = 8'hFF;
  localparam logic [2:0]  PLM_LOCK_ERASED = 3'h0;
  localparam logic [7:0]  PLM_VERIFY_DENY = 8'hFF;

  // Protection levels; undefined lock combinations map to the top level.
  typedef enum logic [1:0] {
    PLM_LEVEL_OPEN   = 2'b00,
    PLM_LEVEL_BASIC  = 2'b01,
    PLM_LEVEL_NOVFY  = 2'b10,
    PLM_LEVEL_NOEXT  = 2'b11
  } plm_level_type;

endpackage : plm_pkg

/* plm_prog_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Programmer side of the code verify port; it asks for one byte at a time.
module plm_prog_model (
  input  wire logic        pclk,
  input  wire logic        verify_valid,
  input  wire logic [7:0]  verify_data,
  output logic             verify_req,
  output logic [15:0]      verify_addr,
  output logic [7:0]       verify_byte
);
  // Idle levels before the first request.
  initial begin
    verify_req = 1'b0;
    verify_addr = 16'h0000;
    verify_byte = 8'h00;
  end
  task automatic read_back(input logic [15:0] a, input logic [7:0] b,
                           output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge pclk);
    verify_req <= 1'b1;
    verify_addr <= a;
    verify_byte <= b;
    @(posedge pclk);
    verify_req <= 1'b0;
    // Stale data is flipped so a design that samples late sees garbage.
    verify_byte <= ~b;
    verify_addr <= ~a;
    while (verify_valid !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    d = verify_data;
    ok = verify_valid;
  endtask : read_back
endmodule : plm_prog_model
`default_nettype wire

/* plm_top.sv */
// Behaviour
// - No lock bit programmed means no restriction; verify output still encrypted.
// - First lock bit blocks external table reads from fetching internal code bytes.
// - First lock bit: external-access pin latched on the first edge after reset release, later changes ignored.
// - First lock bit refuses further programming of on-chip program memory.
// - First and second lock bits add disabling of code verification.
// - All three lock bits add blocking of external program execution.
// - Only four lock combinations are defined; others are unspecified.
// - Verify output byte is stored byte XNOR key byte taken in sequence.
// - Unprogrammed key bytes are all ones, so verify output is unchanged.
// - Erase clears encryption array and all lock bits.
`timescale 1ns/1ps
`default_nettype none
module plm_top (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 external_access_pin,
  input  wire logic                 verify_req,
  input  wire logic [15:0]          verify_addr,
  input  wire logic [7:0]           verify_byte,
  output logic      [7:0]           verify_data,
  output logic                      verify_valid,
  output logic                      code_table_read_instr_allow,
  output logic                      ext_exec_allow,
  output logic                      prog_enable,
  output logic                      verify_enable,
  output logic                      access_effective,
  output plm_pkg::plm_level_type    level
);
  import plm_pkg::*;

  // Decodes stored lock bits {third, second, first} into a protection level.
  function automatic plm_level_type decode_level(input logic [2:0] lb);
    case (lb)
      3'b000:  decode_level = PLM_LEVEL_OPEN;
      3'b001:  decode_level = PLM_LEVEL_BASIC;
      3'b011:  decode_level = PLM_LEVEL_NOVFY;
      default: decode_level = PLM_LEVEL_NOEXT;
    endcase
  endfunction : decode_level

  logic [2:0]  lock_bits;
  logic [2:0]  next_lock_bits;
  logic [7:0]  key_mem [PLM_KEY_DEPTH];
  logic [7:0]  next_key_mem [PLM_KEY_DEPTH];
  logic        access_latch;
  logic        next_access_latch;
  logic        access_taken;
  logic        next_access_taken;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [7:0]  next_verify_data;
  logic        next_verify_valid;
  plm_level_type next_level;
  logic        apb_setup;
  logic        apb_wr;
  logic        addr_ok;
  logic        erase_cmd;
  logic [7:0]  key_sel;

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;
  assign addr_ok   = (paddr == PLM_CTRL_OFFSET) || (paddr == PLM_STATUS_OFFSET) ||
                     (paddr == PLM_KEY_OFFSET);
  assign erase_cmd = apb_wr && (paddr == PLM_CTRL_OFFSET) && pwdata[PLM_CTRL_ERASE];
  assign key_sel   = key_mem[verify_addr[PLM_KEY_IDX_W-1:0]];

  // Lock bits only ever become programmed; erase and reset are the only ways back.
  always_comb begin
    next_lock_bits = lock_bits;
    for (int i = 0; i < PLM_KEY_DEPTH; i++) begin
      next_key_mem[i] = key_mem[i];
    end
    if (erase_cmd) begin
      next_lock_bits = PLM_LOCK_ERASED;
      for (int i = 0; i < PLM_KEY_DEPTH; i++) begin
        next_key_mem[i] = PLM_KEY_ERASED;
      end
    end else if (apb_wr && (paddr == PLM_CTRL_OFFSET)) begin
      next_lock_bits = lock_bits | pwdata[PLM_CTRL_LOCK_LSB +: 3];
    end else if (apb_wr && (paddr == PLM_KEY_OFFSET) && !lock_bits[0]) begin
      next_key_mem[pwdata[PLM_KEY_INDEX_LSB +: PLM_KEY_IDX_W]] =
        pwdata[PLM_KEY_DATA_LSB +: 8];
    end
  end

  // Nonvolatile store modelled as flops; reset leaves it in the erased state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_bits <= PLM_LOCK_ERASED;
      for (int i = 0; i < PLM_KEY_DEPTH; i++) begin
        key_mem[i] <= PLM_KEY_ERASED;
      end
    end else begin
      lock_bits <= next_lock_bits;
      for (int i = 0; i < PLM_KEY_DEPTH; i++) begin
        key_mem[i] <= next_key_mem[i];
      end
    end
  end

  // The pin is caught on the first edge after reset release, never during reset.
  always_comb begin
    next_access_taken = 1'b1;
    next_access_latch = access_taken ? access_latch : external_access_pin;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_taken <= 1'b0;
      access_latch <= 1'b0;
    end else begin
      access_taken <= next_access_taken;
      access_latch <= next_access_latch;
    end
  end

  // APB slave answers in the first access cycle, so every transfer takes two cycles.
  always_comb begin
    next_pready  = apb_setup;
    next_pslverr = apb_setup && !addr_ok;
    next_prdata  = 32'h0000_0000;
    if (apb_setup && !pwrite) begin
      if (paddr == PLM_CTRL_OFFSET) begin
        next_prdata[PLM_CTRL_LOCK_LSB +: 3] = lock_bits;
      end else if (paddr == PLM_STATUS_OFFSET) begin
        next_prdata[PLM_STAT_LOCK_LSB +: 3]  = lock_bits;
        next_prdata[PLM_STAT_LEVEL_LSB +: 2] = level;
        next_prdata[PLM_STAT_ACCESS]         = access_effective;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Permission outputs are registered so the fetch path sees a glitch-free level.
  always_comb begin
    next_level = decode_level(lock_bits);
    next_verify_valid = verify_req;
    next_verify_data  = verify_data;
    if (verify_req) begin
      next_verify_data = (lock_bits[1:0] == 2'b11) ? PLM_VERIFY_DENY : ~(verify_byte ^ key_sel);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level                       <= PLM_LEVEL_OPEN;
      code_table_read_instr_allow <= 1'b1;
      ext_exec_allow              <= 1'b1;
      prog_enable                 <= 1'b1;
      verify_enable               <= 1'b1;
      access_effective            <= 1'b0;
      verify_data                 <= 8'h00;
      verify_valid                <= 1'b0;
    end else begin
      level                       <= next_level;
      code_table_read_instr_allow <= !lock_bits[0];
      ext_exec_allow              <= (next_level != PLM_LEVEL_NOEXT);
      prog_enable                 <= !lock_bits[0];
      verify_enable               <= (lock_bits[1:0] != 2'b11);
      access_effective            <= lock_bits[0] ? next_access_latch : external_access_pin;
      verify_data                 <= next_verify_data;
      verify_valid                <= next_verify_valid;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_verify_ask;
    verify_req && (lock_bits[1:0] != 2'b11);
  endsequence

  sequence s_verify_answer;
    verify_valid && verify_data == ~($past(verify_byte) ^ $past(key_sel));
  endsequence

  property p_open;
    lock_bits == 3'b000 |=> code_table_read_instr_allow && ext_exec_allow && prog_enable
      && verify_enable && level == PLM_LEVEL_OPEN;
  endproperty
  a_open: assert property (p_open) else $error("open level restricted");

  property p_table_read;
    lock_bits[0] |=> !code_table_read_instr_allow;
  endproperty
  a_table_read: assert property (p_table_read) else $error("table read not blocked");

  // The latch itself must not move once taken, else a live pin would pass unnoticed.
  property p_access_latch;
    lock_bits[0] && access_taken |=> access_effective == $past(access_latch)
      && $stable(access_latch);
  endproperty
  a_access_latch: assert property (p_access_latch) else $error("pin not held latched");

  property p_prog;
    lock_bits[0] |=> !prog_enable;
  endproperty
  a_prog: assert property (p_prog) else $error("programming not refused");

  property p_novfy;
    lock_bits[1:0] == 2'b11 && verify_req |=> !verify_enable && verify_data == PLM_VERIFY_DENY;
  endproperty
  a_novfy: assert property (p_novfy) else $error("verify not disabled");

  property p_noext;
    lock_bits == 3'b111 |=> !ext_exec_allow && !prog_enable;
  endproperty
  a_noext: assert property (p_noext) else $error("external execution not blocked");

  property p_xnor;
    s_verify_ask |=> s_verify_answer;
  endproperty
  a_xnor: assert property (p_xnor) else $error("verify byte not encrypted");

  property p_bypass;
    s_verify_ask ##0 key_sel == PLM_KEY_ERASED |=> verify_data == $past(verify_byte);
  endproperty
  a_bypass: assert property (p_bypass) else $error("erased key changed byte");

  property p_erase;
    erase_cmd |=> lock_bits == PLM_LOCK_ERASED ##1 prog_enable && ext_exec_allow;
  endproperty
  a_erase: assert property (p_erase) else $error("erase did not restore");

  property p_stable;
    $stable(lock_bits) |=> $stable(level);
  endproperty
  a_stable: assert property (p_stable) else $error("level moved without lock change");

endmodule : plm_top
`default_nettype wire

/* plm_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module plm_top_tb;
  import plm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, vreq, vvalid;
  logic [7:0]  paddr, vbyte, vdata;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] vaddr;
  logic        tbl_ok, ext_ok, prog_ok, vfy_ok, acc_eff, er;
  plm_level_type level;
  int          mismatches, checks;

  plm_top u_plm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_access_pin(pin), .verify_req(vreq),
    .verify_addr(vaddr), .verify_byte(vbyte), .verify_data(vdata),
    .verify_valid(vvalid), .code_table_read_instr_allow(tbl_ok),
    .ext_exec_allow(ext_ok), .prog_enable(prog_ok), .verify_enable(vfy_ok),
    .access_effective(acc_eff), .level(level));
  plm_prog_model u_plm_prog_model (.pclk(pclk), .verify_valid(vvalid),
    .verify_data(vdata), .verify_req(vreq), .verify_addr(vaddr), .verify_byte(vbyte));

  // Free-running core clock, 10 ns period.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic stop_test;
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      stop_test();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // Lock changes reach the permission outputs two edges after the write.
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  task automatic perms(input plm_level_type lv, input logic [3:0] allow);
    check({30'h0, level}, {30'h0, lv});
    check({28'h0, tbl_ok, ext_ok, prog_ok, vfy_ok}, {28'h0, allow});
  endtask : perms

  task automatic vfy(input logic [15:0] a, input logic [7:0] b, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    u_plm_prog_model.read_back(a, b, d, ok);
    check({31'h0, ok}, 32'h1);
    check({24'h0, d}, {24'h0, e});
  endtask : vfy

  // Main sequence: walk the lock levels up, then erase and try an odd combination.
  initial begin
    mismatches = 0;
    checks = 0;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    perms(PLM_LEVEL_OPEN, 4'hF);
    apb(1'b0, PLM_STATUS_OFFSET, 32'h0);
    check(rd, 32'h00000100);
    vfy(16'h0105, 8'hA5, 8'hA5);
    apb(1'b1, PLM_KEY_OFFSET, 32'h0000053C);
    vfy(16'h0105, 8'hA5, ~(8'hA5 ^ 8'h3C));
    vfy(16'h0106, 8'h5A, 8'h5A);
    apb(1'b1, PLM_CTRL_OFFSET, 32'h1);
    pin <= 1'b0;
    settle();
    perms(PLM_LEVEL_BASIC, 4'h5);
    check({31'h0, acc_eff}, 32'h1);
    apb(1'b1, PLM_KEY_OFFSET, 32'h00000500);
    vfy(16'h0105, 8'hA5, ~(8'hA5 ^ 8'h3C));
    apb(1'b1, PLM_CTRL_OFFSET, 32'h2);
    settle();
    perms(PLM_LEVEL_NOVFY, 4'h4);
    vfy(16'h0105, 8'hA5, PLM_VERIFY_DENY);
    apb(1'b1, PLM_CTRL_OFFSET, 32'h4);
    settle();
    perms(PLM_LEVEL_NOEXT, 4'h0);
    apb(1'b0, PLM_STATUS_OFFSET, 32'h0);
    check(rd, 32'h00000137);
    apb(1'b0, 8'h0C, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, PLM_CTRL_OFFSET, 32'h100);
    settle();
    perms(PLM_LEVEL_OPEN, 4'hF);
    check({31'h0, acc_eff}, 32'h0);
    vfy(16'h0105, 8'hA5, 8'hA5);
    apb(1'b1, PLM_CTRL_OFFSET, 32'h2);
    settle();
    // First bit clear: table reads, programming and verify stay allowed; only execution stops.
    perms(PLM_LEVEL_NOEXT, 4'hB);
    stop_test();
  end
endmodule : plm_top_tb
`default_nettype wire
